// ==== smcf_defines.vh ====
// Constants for the synchronous-mode receive CRC and transmit fill block.
// Operation
// - One polynomial bit in transmit control: one is CRC-16, zero CRC-CCITT.
// - Preset bit in misc control chooses all ones or all zeros preset.
// - Receive checker stays preset for the whole time the receiver hunts.
// - Command top two bits equal to reset-checker preset the receive checker.
// - Receive CRC accumulates only while receive control bit zero was one at the last character load.
// - Sync characters withheld by load inhibit are excluded from the receive CRC.
// - Received bits pass an eight-bit delay before reaching the checker.
// - Checker enable changes take effect only when a character is loaded.
// - CRC result is latched with each loaded character and held until the next one loads.
// - Entering hunt disables and resets the receive checker.
// - Ready-or-request pin carries inverted terminal-ready unless set to request.
// - With auto-enables, carrier high disables the receiver; else status only.
// - Eight-bit fill sends low sync register; six-bit sends its low six bits.
// - Sixteen-bit fill sends low then high sync register.
// - Twelve-bit sync is receive only; receive syncs left, transmit right justified.
// - With external receive sync, transmit fill is six or eight bits by misc bit zero.
// - Two transmit control bits pick five to eight bits, right justified.
// - Five-bit mode decodes a pre-formatted byte into one to five bits.
// - Enabled parity appends one even or odd bit after the character.
`ifndef SMCF_DEFINES_VH
`define SMCF_DEFINES_VH
`define SMCF_OFF_LINE_STAT   8'h00
`define SMCF_OFF_CMD         8'h00
`define SMCF_OFF_RX_COND     8'h04
`define SMCF_OFF_DATA        8'h08
`define SMCF_OFF_RX_CTRL     8'h0C
`define SMCF_OFF_MODE        8'h10
`define SMCF_OFF_TX_CTRL     8'h14
`define SMCF_OFF_SYNC_LO     8'h18
`define SMCF_OFF_SYNC_HI     8'h1C
`define SMCF_OFF_MISC        8'h28
`define SMCF_RST_BYTE        8'h00
`define SMCF_RST_WORD        32'h0000_0000
`define SMCF_RXC_CRC_EN      0
`define SMCF_RXC_STRIP       1
`define SMCF_RXC_RX_EN       3
`define SMCF_RXC_HUNT        4
`define SMCF_RXC_AUTO        5
`define SMCF_MODE_PAR_EN     0
`define SMCF_MODE_PAR_EVEN   1
`define SMCF_TXC_CRC16       2
`define SMCF_TXC_TX_EN       3
`define SMCF_TXC_BREAK       4
`define SMCF_TXC_TERM_RDY    7
`define SMCF_MISC_SYNC6      0
`define SMCF_MISC_DMA_REQ    2
`define SMCF_MISC_PRESET     7
`define SMCF_CMD_RST_RX_CRC  2'h1
`define SMCF_SYNC_MONO       2'h0
`define SMCF_SYNC_BISYNC     2'h1
`define SMCF_SYNC_EXT        2'h3
`define SMCF_POLY_CRC16      16'h8005
`define SMCF_POLY_CCITT      16'h1021
`define SMCF_CRC_ONES        16'hFFFF
`define SMCF_CRC_ZEROS       16'h0000
`define SMCF_CLK_PERIOD_NS   25
`define SMCF_BIT_TIME_NS     1000
`define SMCF_BIT_CYCLES      ((`SMCF_BIT_TIME_NS) / (`SMCF_CLK_PERIOD_NS))
`endif

// ==== smcf_sync_crc_fill.v ====
// Synchronous-mode receive CRC checker, transmit fill and modem pins.
`timescale 1ns/10ps
`include "smcf_defines.vh"
module smcf_sync_crc_fill (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Serial line and modem pins
  input  wire        rxd,
  input  wire        sync_in_n,
  input  wire        carrier_detect_input,
  output reg         txd,
  output reg         term_ready_req_n
);

  reg  [7:0]  command_reg;
  reg  [7:0]  receive_control_reg;
  reg  [7:0]  mode_select_reg;
  reg  [7:0]  transmit_control_reg;
  reg  [7:0]  sync_low_reg;
  reg  [7:0]  sync_high_reg;
  reg  [7:0]  misc_control_reg;
  reg  [5:0]  bit_cnt_reg;
  reg         bit_tick_reg;
  reg         carrier_reg;
  reg         hunt_reg;
  reg  [15:0] hunt_sr_reg;
  reg  [7:0]  rx_sr_reg;
  reg  [7:0]  rx_dly_reg;
  reg  [3:0]  rx_bits_reg;
  reg         dly_strip_reg;
  reg         crc_active_reg;
  reg  [15:0] rx_crc_reg;
  reg  [7:0]  rx_data_reg;
  reg         rx_full_reg;
  reg         crc_err_reg;
  reg         overrun_reg;
  reg  [15:0] tx_sr_reg;
  reg  [4:0]  tx_cnt_reg;
  reg  [7:0]  tx_buf_reg;
  reg         tx_full_reg;
  reg  [31:0] rdata;
  reg         mapped;
  reg         sync_match;
  reg  [15:0] tx_word;
  reg  [4:0]  tx_len;
  reg  [3:0]  tx_n;
  reg  [7:0]  tx_data;
  reg         tx_par;
  reg  [7:0]  rx_char;

  wire        acc_first = psel & penable & ~pready;
  wire        apb_done  = psel & penable & pready;
  wire        wr_en     = apb_done & pwrite;
  wire        rd_en     = apb_done & ~pwrite;
  wire        wr_cmd    = wr_en & (paddr == `SMCF_OFF_CMD);
  wire        wr_rxc    = wr_en & (paddr == `SMCF_OFF_RX_CTRL);
  wire        wr_data   = wr_en & (paddr == `SMCF_OFF_DATA);
  wire        rd_data   = rd_en & (paddr == `SMCF_OFF_DATA);
  wire        crc16     = transmit_control_reg[`SMCF_TXC_CRC16];
  wire [15:0] poly      = crc16 ? `SMCF_POLY_CRC16 : `SMCF_POLY_CCITT;
  wire [15:0] preset    = misc_control_reg[`SMCF_MISC_PRESET] ?
                          `SMCF_CRC_ONES : `SMCF_CRC_ZEROS;
  wire [1:0]  sync_mode = mode_select_reg[5:4];
  wire        six       = misc_control_reg[`SMCF_MISC_SYNC6];
  // Auto-enables let the carrier pin gate the receiver directly.
  wire        rx_on     = receive_control_reg[`SMCF_RXC_RX_EN] &
                          ~(receive_control_reg[`SMCF_RXC_AUTO] &
                            carrier_detect_input);
  wire        rx_tick   = bit_tick_reg & rx_on;
  wire [15:0] hunt_next = {rxd, hunt_sr_reg[15:1]};
  wire [7:0]  rx_next   = {rxd, rx_sr_reg[7:1]};
  wire [3:0]  rx_len    = len_dec(receive_control_reg[7:6]);
  wire        rx_done   = rx_tick & ~hunt_reg & (rx_bits_reg + 4'h1 == rx_len);
  // Compare is across all eight bits, so only 8-bit syncs strip cleanly.
  wire        strip     = receive_control_reg[`SMCF_RXC_STRIP] &
                          (rx_next == sync_low_reg);
  wire        crc_fb    = rx_crc_reg[15] ^ rx_dly_reg[0];
  wire [15:0] crc_next  = {rx_crc_reg[14:0], 1'b0} ^
                          (crc_fb ? poly : 16'h0000);
  wire [15:0] crc_now   = (rx_tick & ~hunt_reg & crc_active_reg) ?
                          crc_next : rx_crc_reg;
  wire        enter_hunt = ~rx_on |
                          (wr_rxc & pwdata[`SMCF_RXC_HUNT]) |
                          (wr_rxc & pwdata[`SMCF_RXC_RX_EN] &
                           ~receive_control_reg[`SMCF_RXC_RX_EN]);

  function [3:0] len_dec;
    input [1:0] code;
    begin
      case (code)
        2'h0:    len_dec = 4'h5;
        2'h1:    len_dec = 4'h7;
        2'h2:    len_dec = 4'h6;
        default: len_dec = 4'h8;
      endcase
    end
  endfunction

  // Register read mux and address decode.
  always @*
  begin
    mapped = 1'b1;
    rdata  = `SMCF_RST_WORD;
    case (paddr)
      `SMCF_OFF_LINE_STAT: rdata[7:0] = {3'h0, hunt_reg, carrier_reg,
                                         ~tx_full_reg, 1'b0, rx_full_reg};
      `SMCF_OFF_RX_COND:   rdata[7:0] = {1'b0, crc_err_reg, overrun_reg,
                                         5'h00};
      `SMCF_OFF_DATA:      rdata[7:0] = rx_data_reg;
      `SMCF_OFF_RX_CTRL:   rdata[7:0] = receive_control_reg;
      `SMCF_OFF_MODE:      rdata[7:0] = mode_select_reg;
      `SMCF_OFF_TX_CTRL:   rdata[7:0] = transmit_control_reg;
      `SMCF_OFF_SYNC_LO:   rdata[7:0] = sync_low_reg;
      `SMCF_OFF_SYNC_HI:   rdata[7:0] = sync_high_reg;
      `SMCF_OFF_MISC:      rdata[7:0] = misc_control_reg;
      default:             mapped = 1'b0;
    endcase
  end

  // Receive sync compare; receive patterns sit left justified.
  always @*
  begin
    sync_match = 1'b0;
    case (sync_mode)
      `SMCF_SYNC_MONO:
        sync_match = six ? (hunt_next[15:10] == sync_high_reg[7:2]) :
                           (hunt_next[15:8] == sync_high_reg);
      `SMCF_SYNC_BISYNC:
        sync_match = six ?
          (hunt_next[15:4] == {sync_high_reg, sync_low_reg[7:4]}) :
          (hunt_next == {sync_high_reg, sync_low_reg});
      `SMCF_SYNC_EXT:
        sync_match = ~sync_in_n;
      default:
        sync_match = 1'b0;
    endcase
  end

  // Received character, right justified.
  always @*
  begin
    case (rx_len)
      4'h5:    rx_char = {3'h0, rx_next[7:3]};
      4'h6:    rx_char = {2'h0, rx_next[7:2]};
      4'h7:    rx_char = {1'b0, rx_next[7:1]};
      default: rx_char = rx_next;
    endcase
  end

  // Next transmit word: data with parity, or sync time fill.
  always @*
  begin
    tx_n = len_dec(transmit_control_reg[6:5]);
    if (transmit_control_reg[6:5] == 2'h0)
    begin
      // Leading ones mark how many of the five bits are sent.
      casez (tx_buf_reg[7:4])
        4'b1111: tx_n = 4'h1;
        4'b1110: tx_n = 4'h2;
        4'b110?: tx_n = 4'h3;
        4'b10??: tx_n = 4'h4;
        default: tx_n = 4'h5;
      endcase
    end
    tx_data = tx_buf_reg & ~(8'hFF << tx_n);
    tx_par  = ^tx_data ^ ~mode_select_reg[`SMCF_MODE_PAR_EVEN];
    tx_word = {8'h00, tx_data};
    tx_len  = {1'b0, tx_n};
    if (mode_select_reg[`SMCF_MODE_PAR_EN])
    begin
      tx_word = tx_word | ({15'h0000, tx_par} << tx_n);
      tx_len  = tx_len + 5'h01;
    end
    if (!tx_full_reg)
    begin
      if (sync_mode == `SMCF_SYNC_BISYNC)
      begin
        tx_word = {sync_high_reg, sync_low_reg};
        tx_len  = 5'h10;
      end
      else if (six)
      begin
        tx_word = {10'h000, sync_low_reg[5:0]};
        tx_len  = 5'h06;
      end
      else
      begin
        tx_word = {8'h00, sync_low_reg};
        tx_len  = 5'h08;
      end
    end
  end

  // APB slave: one wait state, then pready for a single cycle.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `SMCF_RST_WORD;
    end
    else
    begin
      pready <= acc_first;
      if (acc_first)
      begin
        prdata  <= pwrite ? `SMCF_RST_WORD : rdata;
        pslverr <= ~mapped;
      end
      else
        pslverr <= 1'b0;
    end
  end

  // Software registers.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      command_reg          <= `SMCF_RST_BYTE;
      receive_control_reg  <= `SMCF_RST_BYTE;
      mode_select_reg      <= `SMCF_RST_BYTE;
      transmit_control_reg <= `SMCF_RST_BYTE;
      sync_low_reg         <= `SMCF_RST_BYTE;
      sync_high_reg        <= `SMCF_RST_BYTE;
      misc_control_reg     <= `SMCF_RST_BYTE;
    end
    else if (wr_en)
    begin
      case (paddr)
        `SMCF_OFF_CMD:     command_reg <= pwdata[7:0];
        `SMCF_OFF_RX_CTRL: receive_control_reg <=
                             {pwdata[7:5], 1'b0, pwdata[3:0]};
        `SMCF_OFF_MODE:    mode_select_reg <= pwdata[7:0];
        `SMCF_OFF_TX_CTRL: transmit_control_reg <= pwdata[7:0];
        `SMCF_OFF_SYNC_LO: sync_low_reg <= pwdata[7:0];
        `SMCF_OFF_SYNC_HI: sync_high_reg <= pwdata[7:0];
        `SMCF_OFF_MISC:    misc_control_reg <= pwdata[7:0];
        default:           command_reg <= command_reg;
      endcase
    end
  end

  // Bit-time enable from the core clock.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      bit_cnt_reg  <= 6'h00;
      bit_tick_reg <= 1'b0;
    end
    else if ({26'h000_0000, bit_cnt_reg} == `SMCF_BIT_CYCLES - 1)
    begin
      bit_cnt_reg  <= 6'h00;
      bit_tick_reg <= 1'b1;
    end
    else
    begin
      bit_cnt_reg  <= bit_cnt_reg + 6'h01;
      bit_tick_reg <= 1'b0;
    end
  end

  // Receive hunt, assembly, delay stage and CRC checker.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      carrier_reg    <= 1'b0;
      hunt_reg       <= 1'b1;
      hunt_sr_reg    <= 16'h0000;
      rx_sr_reg      <= 8'h00;
      rx_dly_reg     <= 8'h00;
      rx_bits_reg    <= 4'h0;
      dly_strip_reg  <= 1'b0;
      crc_active_reg <= 1'b0;
      rx_crc_reg     <= `SMCF_CRC_ZEROS;
      rx_data_reg    <= 8'h00;
      rx_full_reg    <= 1'b0;
      crc_err_reg    <= 1'b0;
      overrun_reg    <= 1'b0;
    end
    else
    begin
      carrier_reg <= carrier_detect_input;
      if (rd_data)
      begin
        rx_full_reg <= 1'b0;
        overrun_reg <= 1'b0;
      end
      if (enter_hunt | hunt_reg)
      begin
        // Hunt keeps the checker disabled and preset.
        crc_active_reg <= 1'b0;
        rx_crc_reg     <= preset;
        rx_bits_reg    <= 4'h0;
        // No data character sits in the delay yet, so keep it out of the
        // CRC even when the host enabled the checker before the block.
        dly_strip_reg  <= 1'b1;
      end
      if (enter_hunt)
        hunt_reg <= 1'b1;
      else if (hunt_reg & rx_tick)
      begin
        hunt_sr_reg <= hunt_next;
        if (sync_match)
          hunt_reg <= 1'b0;
      end
      else if (rx_tick)
      begin
        rx_sr_reg   <= rx_next;
        rx_dly_reg  <= {rx_sr_reg[0], rx_dly_reg[7:1]};
        rx_crc_reg  <= crc_now;
        rx_bits_reg <= rx_done ? 4'h0 : rx_bits_reg + 4'h1;
        if (rx_done)
        begin
          // The character leaving the delay next was stripped if flagged.
          dly_strip_reg <= strip;
          if (!strip)
          begin
            rx_data_reg    <= rx_char;
            rx_full_reg    <= 1'b1;
            overrun_reg    <= rx_full_reg & ~rd_data;
            crc_err_reg    <= (crc_now != `SMCF_CRC_ZEROS);
            crc_active_reg <= receive_control_reg[`SMCF_RXC_CRC_EN] &
                              ~dly_strip_reg;
          end
          else
            crc_active_reg <= crc_active_reg & ~dly_strip_reg;
        end
      end
      // Reset command wins over accumulation in the same cycle.
      if (wr_cmd && pwdata[7:6] == `SMCF_CMD_RST_RX_CRC)
        rx_crc_reg <= preset;
    end
  end

  // Transmitter, LSB first; idles marking or spacing when disabled.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      tx_sr_reg   <= 16'h0000;
      tx_cnt_reg  <= 5'h00;
      tx_buf_reg  <= 8'h00;
      tx_full_reg <= 1'b0;
      txd         <= 1'b1;
    end
    else
    begin
      if (bit_tick_reg)
      begin
        if (tx_cnt_reg != 5'h00)
        begin
          txd        <= tx_sr_reg[0];
          tx_sr_reg  <= {1'b0, tx_sr_reg[15:1]};
          tx_cnt_reg <= tx_cnt_reg - 5'h01;
        end
        else if (transmit_control_reg[`SMCF_TXC_TX_EN])
        begin
          txd         <= tx_word[0];
          tx_sr_reg   <= {1'b0, tx_word[15:1]};
          tx_cnt_reg  <= tx_len - 5'h01;
          tx_full_reg <= 1'b0;
        end
        else
          txd <= ~transmit_control_reg[`SMCF_TXC_BREAK];
      end
      // A write in the load cycle still marks the buffer full.
      if (wr_data)
      begin
        tx_buf_reg  <= pwdata[7:0];
        tx_full_reg <= 1'b1;
      end
    end
  end

  // Terminal-ready pin, or receive request when so programmed.
  always @(posedge core_clk)
  begin
    if (!rstn)
      term_ready_req_n <= 1'b1;
    else if (misc_control_reg[`SMCF_MISC_DMA_REQ])
      term_ready_req_n <= ~rx_full_reg;
    else
      term_ready_req_n <= ~transmit_control_reg[`SMCF_TXC_TERM_RDY];
  end

endmodule // smcf_sync_crc_fill

// ==== smcf_sync_crc_fill_props.sv ====
// Concurrent checks on the bus and pin behaviour of the sync block.
`timescale 1ns/10ps
`include "smcf_defines.vh"
module smcf_sync_crc_fill_props (
  // Clock and reset
  input wire        core_clk,
  input wire        rstn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pins
  input wire        carrier_detect_input,
  input wire        txd,
  input wire        term_ready_req_n
);
  reg        rdy_reg;
  reg        dma_reg;
  reg        txen_reg;
  reg        brk_reg;
  reg        car_q_reg;
  reg        txd_q_reg;
  reg [11:0] quiet_reg;
  reg [11:0] car_cnt_reg;
  reg [11:0] gap_reg;
  wire       commit;
  assign commit = psel & penable & pready & pwrite & ~pslverr;
  // Shadows follow committed writes, so no internal view is needed.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      rdy_reg <= 1'b0;
      dma_reg <= 1'b0;
      txen_reg <= 1'b0;
      brk_reg <= 1'b0;
      quiet_reg <= 12'h000;
      car_cnt_reg <= 12'h000;
      gap_reg <= 12'h028;
    end
    else
    begin
      if (commit && paddr == `SMCF_OFF_TX_CTRL)
      begin
        rdy_reg <= pwdata[`SMCF_TXC_TERM_RDY];
        txen_reg <= pwdata[`SMCF_TXC_TX_EN];
        brk_reg <= pwdata[`SMCF_TXC_BREAK];
      end
      if (commit && paddr == `SMCF_OFF_MISC)
        dma_reg <= pwdata[`SMCF_MISC_DMA_REQ];
      quiet_reg <= commit ? 12'h000 : quiet_reg + {11'h000, ~&quiet_reg};
      car_cnt_reg <= (carrier_detect_input != car_q_reg) ? 12'h000 :
                     car_cnt_reg + {11'h000, ~&car_cnt_reg};
      gap_reg <= (txd != txd_q_reg) ? 12'h000 :
                 gap_reg + {11'h000, ~&gap_reg};
    end
    car_q_reg <= carrier_detect_input;
    txd_q_reg <= txd;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  apb_wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready did not follow the first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  error_qualified_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  bad_read_zero_a: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  term_pin_a: assert property (
    !dma_reg && quiet_reg >= 12'd3 |-> term_ready_req_n == !rdy_reg)
    else $error("ready pin does not mirror the inverted bit");
  txd_hold_a: assert property ($changed(txd) |-> gap_reg >= 12'd39)
    else $error("serial output changed inside a bit time");
  tx_idle_a: assert property (!txen_reg && quiet_reg >= 12'd800
    |-> txd == !brk_reg)
    else $error("idle serial level wrong");
  carrier_status_a: assert property (
    pready && !pwrite && !pslverr && paddr == `SMCF_OFF_LINE_STAT &&
    car_cnt_reg >= 12'd4 |-> prdata[3] == carrier_detect_input)
    else $error("carrier status bit does not follow the pin");
endmodule // smcf_sync_crc_fill_props
bind smcf_sync_crc_fill smcf_sync_crc_fill_props u_props (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd(txd),
  .carrier_detect_input(carrier_detect_input),
  .term_ready_req_n(term_ready_req_n));

// ==== smcf_line_peer.sv ====
// Serial line peer: drives received bits and marks mid-bit instants.
`timescale 1ns/10ps
module smcf_line_peer (
  // Clock and reset
  input  wire core_clk,
  input  wire rstn,
  // Line
  output reg  rxd,
  output wire mid_bit
);
  reg [5:0] phase_reg;
  assign mid_bit = (phase_reg == 6'h14);
  // Bit edges sit half a bit from the sampling tick for margin.
  always @(posedge core_clk)
  begin
    if (!rstn)
      phase_reg <= 6'h00;
    else
      phase_reg <= (phase_reg == 6'h27) ? 6'h00 : phase_reg + 6'h01;
  end
  initial rxd = 1'b1;
  // Least significant bit first, bytes back to back within a block.
  task send_byte(input [7:0] b);
    integer j;
    begin
      for (j = 0; j < 8; j = j + 1)
      begin
        @(posedge core_clk iff mid_bit);
        rxd <= b[j];
      end
    end
  endtask
  // The line marks between blocks instead of holding the last bit.
  task line_idle;
    begin
      @(posedge core_clk iff mid_bit);
      rxd <= 1'b1;
    end
  endtask
endmodule // smcf_line_peer

// ==== smcf_sync_crc_fill_tb_top.sv ====
// Self-checking bench for the sync-mode CRC checker and transmit fill.
`timescale 1ns/10ps
`include "smcf_defines.vh"
module smcf_sync_crc_fill_tb_top;
  reg         core_clk;
  reg         rstn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        rxd;
  reg         sync_in_n;
  reg         carrier_detect_input;
  wire        txd;
  wire        term_ready_req_n;
  wire        mid_bit;
  integer     error_cnt;
  integer     checks_done;
  integer     seed;
  integer     i;
  integer     k;
  integer     m;
  reg  [31:0] q;
  reg         e;
  reg         rdy;
  reg         rc;
  reg  [7:0]  rb;
  reg  [63:0] cap;
  reg  [7:0]  d [0:9];
  reg  [15:0] crc;
  reg  [15:0] poly;
  reg  [15:0] pat;
  reg  [4:0]  flen;
  reg  [1:0]  sm;
  smcf_sync_crc_fill u_smcf_sync_crc_fill (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .sync_in_n(sync_in_n),
    .carrier_detect_input(carrier_detect_input), .txd(txd),
    .term_ready_req_n(term_ready_req_n));
  smcf_line_peer u_smcf_line_peer (
    .core_clk(core_clk), .rstn(rstn), .rxd(rxd), .mid_bit(mid_bit));
  always #12.5 core_clk = ~core_clk;
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("unexpected %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] wd);
    integer n;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge core_clk);
        n = n + 1;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
        error_cnt = error_cnt + 1;
        print_verdict;
      end
    end
  endtask
  // Polls for a character, then takes its status before its data.
  task rx_char(output [7:0] dat, output cond);
    integer n;
    begin
      n = 0;
      q = 32'h0000_0000;
      while (q[0] !== 1'b1 && n < 400)
      begin
        apb(1'b0, `SMCF_OFF_LINE_STAT, 32'h0000_0000);
        n = n + 1;
      end
      if (q[0] !== 1'b1)
      begin
        error_cnt = error_cnt + 1;
        print_verdict;
      end
      apb(1'b0, `SMCF_OFF_RX_COND, 32'h0000_0000);
      cond = q[6];
      apb(1'b0, `SMCF_OFF_DATA, 32'h0000_0000);
      dat = q[7:0];
    end
  endtask
  function [15:0] crc_byte(input [15:0] c, input [7:0] b, input [15:0] p);
    integer j;
    begin
      crc_byte = c;
      for (j = 0; j < 8; j = j + 1)
        crc_byte = {crc_byte[14:0], 1'b0} ^
                   ((crc_byte[15] ^ b[j]) ? p : 16'h0000);
    end
  endfunction
  function [7:0] rev(input [7:0] b);
    integer j;
    begin
      for (j = 0; j < 8; j = j + 1)
        rev[j] = b[7 - j];
    end
  endfunction
  // True when the captured stream repeats the pattern at some phase.
  function match(input [63:0] c, input [15:0] p, input [4:0] len);
    integer a;
    integer b;
    reg ok;
    begin
      match = 1'b0;
      for (a = 0; a < len; a = a + 1)
      begin
        ok = 1'b1;
        for (b = 0; b < 2 * len; b = b + 1)
          if (c[a + b] !== p[b % len])
            ok = 1'b0;
        if (ok)
          match = 1'b1;
      end
    end
  endfunction
  initial
  begin
    core_clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sync_in_n = 1'b1;
    carrier_detect_input = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    seed = 32'hd754;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b0, `SMCF_OFF_LINE_STAT, 32'h0000_0000);
    chk(q & 32'hFFFF_FF11, 32'h0000_0010, "reset status");
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk(e, 1'b1, "unmapped error");
    chk(q, 32'h0000_0000, "unmapped data");
    // Fill table: mono 8, mono 6, bisync 16, external 6, external 8.
    for (i = 0; i < 5; i = i + 1)
    begin
      pat = $random(seed);
      sm = (i == 2) ? 2'h1 : ((i > 2) ? 2'h3 : 2'h0);
      flen = (i % 2) ? 5'd6 : ((i == 2) ? 5'd16 : 5'd8);
      apb(1'b1, `SMCF_OFF_MODE, {26'h0, sm, 4'h0});
      apb(1'b1, `SMCF_OFF_MISC, i % 2);
      apb(1'b1, `SMCF_OFF_SYNC_LO, {24'h0, pat[7:0]});
      apb(1'b1, `SMCF_OFF_SYNC_HI, {24'h0, pat[15:8]});
      apb(1'b1, `SMCF_OFF_TX_CTRL, 32'h0000_0068);
      repeat (40) @(posedge core_clk iff mid_bit);
      for (k = 0; k < 64; k = k + 1)
      begin
        @(posedge core_clk iff mid_bit);
        cap[k] = txd;
      end
      chk(match(cap, pat, flen), 1'b1, "fill");
      apb(1'b0, `SMCF_OFF_SYNC_HI, 32'h0000_0000);
      chk(q, {24'h00_0000, pat[15:8]}, "sync readback");
    end
    // Blocks with both polynomials; the last one uses a wrong preset.
    for (i = 0; i < 4; i = i + 1)
    begin
      poly = i[0] ? `SMCF_POLY_CRC16 : `SMCF_POLY_CCITT;
      rdy = $random(seed);
      carrier_detect_input <= $random(seed);
      // Redraw until no byte mimics the sync, which stripping would drop.
      do
      begin
        crc = (i == 2) ? `SMCF_CRC_ONES : `SMCF_CRC_ZEROS;
        rb = 8'h00;
        for (k = 0; k < 10; k = k + 1)
        begin
          d[k] = $random(seed);
          if (k < 6)
            crc = crc_byte(crc, d[k], poly);
        end
        d[6] = rev(crc[15:8]);
        d[7] = rev(crc[7:0]);
        for (k = 0; k < 10; k = k + 1)
          if (d[k] == 8'h3C)
            rb = 8'h01;
      end
      while (rb != 8'h00);
      apb(1'b1, `SMCF_OFF_MODE, 32'h0000_0000);
      apb(1'b1, `SMCF_OFF_MISC, {24'h0, i[1], 7'h00});
      apb(1'b1, `SMCF_OFF_SYNC_LO, 32'h0000_003C);
      apb(1'b1, `SMCF_OFF_SYNC_HI, 32'h0000_003C);
      apb(1'b1, `SMCF_OFF_RX_CTRL, 32'h0000_00C0);
      apb(1'b1, `SMCF_OFF_TX_CTRL, {24'h0, rdy, 3'h6, 1'b1, i[0], 2'h0});
      // Odd blocks rely on the preset held while hunting.
      if (!i[0])
        apb(1'b1, `SMCF_OFF_CMD, 32'h0000_0040);
      // Odd blocks strip syncs with the checker on from the start.
      apb(1'b1, `SMCF_OFF_RX_CTRL,
          {24'h0, 6'h32, i[0], i[0]});
      chk(term_ready_req_n, !rdy, "ready pin");
      fork
        begin
          u_smcf_line_peer.send_byte(8'h3C);
          if (i[0])
            u_smcf_line_peer.send_byte(8'h3C);
          for (k = 0; k < 10; k = k + 1)
            u_smcf_line_peer.send_byte(d[k]);
          u_smcf_line_peer.line_idle;
        end
        begin
          rx_char(rb, rc);
          chk(rb, d[0], "first data");
          apb(1'b1, `SMCF_OFF_RX_CTRL,
              {24'h0, 6'h32, i[0], 1'b1});
          for (m = 1; m < 10; m = m + 1)
          begin
            rx_char(rb, rc);
            chk(rb, d[m], "data");
          end
          chk(rc, i == 3, "crc error");
        end
      join
    end
    apb(1'b1, `SMCF_OFF_TX_CTRL, 32'h0000_0080);
    repeat (900) @(posedge core_clk);
    chk(txd, 1'b1, "idle mark");
    chk(term_ready_req_n, 1'b0, "ready pin set");
    apb(1'b1, `SMCF_OFF_TX_CTRL, 32'h0000_0010);
    repeat (900) @(posedge core_clk);
    chk(txd, 1'b0, "break level");
    print_verdict;
  end
endmodule // smcf_sync_crc_fill_tb_top
